// ==== design/join_filter.sv ====
// Beacon acceptance check for an end device looking for a coordinator
`timescale 1ns/1ps
`default_nettype none
`include "net_join_regs.svh"

module join_filter (
    input wire logic [3:0] edOpts,       // End-device option bits
    input wire logic [15:0] ownNet,      // Own network identifier
    input wire logic [4:0] ownChan,      // Own channel setting
    input wire logic localBeacon,        // Own network is beacon-enabled
    input wire logic [15:0] beaconNet,   // Identifier of heard coordinator
    input wire logic [4:0] beaconChan,   // Channel of heard coordinator
    input wire logic beaconPermit,       // Coordinator permits joining
    input wire logic beaconMode,         // Coordinator sends beacons
    output logic [7:0] verdict           // Zero accepts, else reject code
);

    // First failing check wins, in code order
    always_comb begin
        if (!beaconPermit) begin
            verdict = `RC_NOT_PERMITTED;
        end else if (beaconMode != localBeacon) begin
            verdict = `RC_BEACON_MISMATCH;
        end else if (!edOpts[`ED_ANY_NETID] && beaconNet != ownNet) begin
            verdict = `RC_NETID_MISMATCH;
        end else if (!edOpts[`ED_ANY_CHANNEL] && beaconChan != ownChan) begin
            verdict = `RC_CHANNEL_MISMATCH;
        end else begin
            verdict = `RC_OK;
        end
    end

endmodule
`default_nettype wire

// ==== design/net_join_pkg.sv ====
// Types shared by the association control logic
package net_join_pkg;

    // ==========================================================
    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ASCAN = 3'h1,
        ST_ESCAN = 3'h2,
        ST_ASSOC = 3'h3,
        ST_JOINED = 3'h4,
        ST_START = 3'h5,
        ST_COORD = 3'h6,
        ST_HOLD = 3'h7
    } state_t;

    // ==========================================================
    // Whole state of the control block
    typedef struct packed {
        state_t state;
        logic [3:0] edOpts;
        logic [2:0] coOpts;
        logic [7:0] code;
        logic [7:0] paramRdata;
        logic paramError;
        logic activeScanReq;
        logic energyScanReq;
        logic assocReq;
        logic startReq;
        logic pollReq;
        logic disassocReq;
        logic pollPending;
        logic joined;
        logic permit;
        logic cand;
        logic seen;
        logic [7:0] reject;
        logic [15:0] workNet;
        logic [4:0] workChan;
        logic [3:0] scanExp;
        logic [17:0] holdCnt;
    } ctrl_t;

endpackage

// ==== design/net_join_regs.svh ====
// Parameter selects, field positions, reset values, result codes and timing
`ifndef NET_JOIN_REGS_SVH
`define NET_JOIN_REGS_SVH

// ==========================================================
// Parameter selects
`define PAR_ED_OPTS 2'h0
`define PAR_CO_OPTS 2'h1
`define PAR_RESULT 2'h2

// ==========================================================
// Field positions
`define ED_ANY_NETID 0
`define ED_ANY_CHANNEL 1
`define ED_AUTO_JOIN 2
`define ED_POLL_ON_WAKE 3
`define CO_NETID_REASSIGN 0
`define CO_CHANNEL_REASSIGN 1
`define CO_JOIN_PERMIT 2

// ==========================================================
// Reset values and write limits
`define ED_OPTS_RESET 4'h0
`define CO_OPTS_RESET 3'h6
`define ED_OPTS_MAX 8'h0f
`define CO_OPTS_MAX 8'h07

// ==========================================================
// Result codes
`define RC_OK 8'h00
`define RC_ASCAN_TIMEOUT 8'h01
`define RC_NO_NETWORK 8'h02
`define RC_NOT_PERMITTED 8'h03
`define RC_BEACON_MISMATCH 8'h04
`define RC_NETID_MISMATCH 8'h05
`define RC_CHANNEL_MISMATCH 8'h06
`define RC_ESCAN_TIMEOUT 8'h07
`define RC_START_FAILED 8'h08
`define RC_START_BAD_PARAM 8'h09
`define RC_REALIGNING 8'h0a
`define RC_REQ_NOT_SENT 8'h0b
`define RC_REQ_LAST 8'h10
`define RC_SYNC_LOSS 8'h12
`define RC_DISASSOCIATED 8'h13
`define RC_BUSY 8'hff

// ==========================================================
// Timing
`define CLK_MHZ 200
`define RETRY_HOLD_US 1000
`define RETRY_HOLD_CYC ((`RETRY_HOLD_US) * (`CLK_MHZ))

`endif

// ==== design/network_association_control.sv ====
// Association control and status for a low-rate wireless network node
`timescale 1ns/1ps
`default_nettype none
`include "net_join_regs.svh"

module network_association_control #(
    parameter int RETRY_HOLD_CYCLES = `RETRY_HOLD_CYC
) (
    input wire logic mclk,                 // 200 MHz clock
    input wire logic nrst,                 // Synchronous reset, low
    input wire logic paramWrite,           // Parameter write strobe
    input wire logic [1:0] paramAddr,      // Parameter select
    input wire logic [7:0] paramWdata,     // Parameter write value
    output logic [7:0] paramRdata,         // Selected parameter value
    output logic paramError,               // Write value out of range
    input wire logic commandMode,          // Host is in command mode
    input wire logic applyChanges,         // Settings applied, restart
    input wire logic forceLeave,           // Force-leave command
    input wire logic forcePoll,            // Force-poll command
    input wire logic roleCoord,            // Role: 0 end device, 1 coord
    input wire logic beaconEnabled,        // Network uses beacons
    input wire logic [15:0] networkId,     // Configured network id
    input wire logic [4:0] channelSetting, // Configured channel
    input wire logic [3:0] scanDurExp,     // Scan duration exponent
    input wire logic pinWake,              // Wake by pin, pulse
    output logic activeScanReq,            // Start active scan, pulse
    output logic energyScanReq,            // Start energy scan, pulse
    output logic [3:0] scanExponent,       // Exponent for the scan
    input wire logic scanDone,             // Scan finished, pulse
    input wire logic scanTimeout,          // Scan ended by timeout
    input wire logic beaconValid,          // Beacon heard, pulse
    input wire logic [15:0] beaconNet,     // Beacon network id
    input wire logic [4:0] beaconChan,     // Beacon channel
    input wire logic beaconPermit,         // Beacon permits joining
    input wire logic beaconMode,           // Beacon sender is beaconing
    input wire logic [4:0] quietChannel,   // Quietest channel of scan
    output logic assocReq,                 // Send join request, pulse
    output logic [15:0] targetNet,         // Network id in use
    output logic [4:0] targetChan,         // Channel in use
    input wire logic assocDone,            // Join answer, pulse
    input wire logic [7:0] assocStatus,    // 0 joined, else fault code
    output logic startReq,                 // Start coordinator, pulse
    input wire logic startDone,            // Start answer, pulse
    input wire logic [1:0] startStatus,    // 0 ok, 1 fail, 2 param, 3 realign
    input wire logic syncLoss,             // Beacon sync lost, pulse
    input wire logic linkLost,             // Association lost, pulse
    output logic pollReq,                  // Poll coordinator, pulse
    output logic disassocReq,              // Leave coordinator, pulse
    output logic joined,                   // End device is associated
    output logic permitJoin                // Coordinator accepts joins
);

    // ==========================================================
    // State
    net_join_pkg::ctrl_t s;
    net_join_pkg::ctrl_t next_s;
    logic [7:0] verdict;
    logic attemptAllowed;

    join_filter filter (
        .edOpts(s.edOpts),
        .ownNet(networkId),
        .ownChan(channelSetting),
        .localBeacon(beaconEnabled),
        .beaconNet(beaconNet),
        .beaconChan(beaconChan),
        .beaconPermit(beaconPermit),
        .beaconMode(beaconMode),
        .verdict(verdict)
    );

    // Beacon networks join regardless of the auto-join bit
    assign attemptAllowed = s.edOpts[`ED_AUTO_JOIN] || beaconEnabled;

    // ==========================================================
    // Next state
    always_comb begin
        next_s = s;
        next_s.paramError = 1'b0;
        next_s.activeScanReq = 1'b0;
        next_s.energyScanReq = 1'b0;
        next_s.assocReq = 1'b0;
        next_s.startReq = 1'b0;
        next_s.pollReq = 1'b0;
        next_s.disassocReq = 1'b0;

        // Parameter port; result code writes fall through untouched
        if (paramWrite) begin
            if (paramAddr == `PAR_ED_OPTS) begin
                if (paramWdata <= `ED_OPTS_MAX) begin
                    next_s.edOpts = paramWdata[3:0];
                end else begin
                    next_s.paramError = 1'b1;
                end
            end else if (paramAddr == `PAR_CO_OPTS) begin
                if (paramWdata <= `CO_OPTS_MAX) begin
                    next_s.coOpts = paramWdata[2:0];
                end else begin
                    next_s.paramError = 1'b1;
                end
            end
        end
        unique case (paramAddr)
            `PAR_ED_OPTS: next_s.paramRdata = {4'h0, s.edOpts};
            `PAR_CO_OPTS: next_s.paramRdata = {5'h0, s.coOpts};
            `PAR_RESULT: next_s.paramRdata = s.code;
            default: next_s.paramRdata = 8'h00;
        endcase

        // Polls are held back so no indirect data lands in command mode
        if (s.pollPending && !commandMode && s.state == net_join_pkg::ST_JOINED) begin
            next_s.pollReq = 1'b1;
            next_s.pollPending = 1'b0;
        end
        if (roleCoord) begin
            next_s.pollPending = 1'b0;
        end else if (forcePoll ||
                (pinWake && s.edOpts[`ED_POLL_ON_WAKE])) begin
            next_s.pollPending = 1'b1;
        end

        next_s.permit = roleCoord && s.state == net_join_pkg::ST_COORD &&
            s.coOpts[`CO_JOIN_PERMIT];

        unique case (s.state)
            net_join_pkg::ST_IDLE: begin
                next_s.cand = 1'b0;
                next_s.seen = 1'b0;
                next_s.joined = 1'b0;
                next_s.workNet = networkId;
                next_s.workChan = channelSetting;
                next_s.scanExp = scanDurExp;
                if (roleCoord) begin
                    next_s.code = `RC_BUSY;
                    if (s.coOpts[`CO_NETID_REASSIGN]) begin
                        next_s.state = net_join_pkg::ST_ASCAN;
                        next_s.activeScanReq = 1'b1;
                    end else if (s.coOpts[`CO_CHANNEL_REASSIGN]) begin
                        next_s.state = net_join_pkg::ST_ESCAN;
                        next_s.energyScanReq = 1'b1;
                    end else begin
                        next_s.state = net_join_pkg::ST_START;
                        next_s.startReq = 1'b1;
                    end
                end else if (attemptAllowed) begin
                    next_s.code = `RC_BUSY;
                    next_s.state = net_join_pkg::ST_ASCAN;
                    next_s.activeScanReq = 1'b1;
                end
            end
            net_join_pkg::ST_ASCAN: begin
                if (beaconValid) begin
                    if (roleCoord) begin
                        if (beaconNet == s.workNet) begin
                            next_s.workNet = 16'(s.workNet + 16'h1);
                        end
                    end else if (!s.cand) begin
                        if (verdict == `RC_OK) begin
                            next_s.cand = 1'b1;
                            next_s.workNet = beaconNet;
                            next_s.workChan = beaconChan;
                        end else begin
                            next_s.seen = 1'b1;
                            next_s.reject = verdict;
                        end
                    end
                end
                if (scanDone) begin
                    if (scanTimeout) begin
                        next_s.code = `RC_ASCAN_TIMEOUT;
                        next_s.state = net_join_pkg::ST_HOLD;
                    end else if (roleCoord) begin
                        if (s.coOpts[`CO_CHANNEL_REASSIGN]) begin
                            next_s.state = net_join_pkg::ST_ESCAN;
                            next_s.energyScanReq = 1'b1;
                        end else begin
                            next_s.state = net_join_pkg::ST_START;
                            next_s.startReq = 1'b1;
                        end
                    end else if (s.cand) begin
                        next_s.state = net_join_pkg::ST_ASSOC;
                        next_s.assocReq = 1'b1;
                    end else begin
                        next_s.code = s.seen ? s.reject : `RC_NO_NETWORK;
                        next_s.state = net_join_pkg::ST_HOLD;
                    end
                end
            end
            net_join_pkg::ST_ESCAN: begin
                if (scanDone) begin
                    if (scanTimeout) begin
                        next_s.code = `RC_ESCAN_TIMEOUT;
                        next_s.state = net_join_pkg::ST_HOLD;
                    end else begin
                        next_s.workChan = quietChannel;
                        next_s.state = net_join_pkg::ST_START;
                        next_s.startReq = 1'b1;
                    end
                end
            end
            net_join_pkg::ST_START: begin
                if (startDone) begin
                    if (startStatus == 2'h0) begin
                        next_s.code = `RC_OK;
                        next_s.state = net_join_pkg::ST_COORD;
                    end else begin
                        // Status 1..3 maps onto 0x08..0x0a
                        next_s.code = 8'(`RC_START_FAILED +
                            {6'h0, startStatus} - 8'h01);
                        next_s.state = net_join_pkg::ST_HOLD;
                    end
                end
            end
            net_join_pkg::ST_COORD: begin
                next_s.state = net_join_pkg::ST_COORD;
            end
            net_join_pkg::ST_ASSOC: begin
                if (assocDone) begin
                    if (assocStatus == `RC_OK) begin
                        next_s.code = `RC_OK;
                        next_s.joined = 1'b1;
                        next_s.state = net_join_pkg::ST_JOINED;
                    end else begin
                        // Unknown faults are reported as not sent
                        if (assocStatus >= `RC_REQ_NOT_SENT &&
                                assocStatus <= `RC_REQ_LAST) begin
                            next_s.code = assocStatus;
                        end else begin
                            next_s.code = `RC_REQ_NOT_SENT;
                        end
                        next_s.state = net_join_pkg::ST_HOLD;
                    end
                end
            end
            net_join_pkg::ST_JOINED: begin
                if (forceLeave) begin
                    next_s.disassocReq = 1'b1;
                    next_s.joined = 1'b0;
                    next_s.state = net_join_pkg::ST_IDLE;
                end else if (syncLoss) begin
                    next_s.code = `RC_SYNC_LOSS;
                    next_s.joined = 1'b0;
                    next_s.state = net_join_pkg::ST_HOLD;
                end else if (linkLost) begin
                    next_s.code = `RC_DISASSOCIATED;
                    next_s.joined = 1'b0;
                    next_s.state = net_join_pkg::ST_HOLD;
                end
            end
            net_join_pkg::ST_HOLD: begin
                // Pause between attempts keeps the failure code readable
                if (s.holdCnt == 18'h0 || forceLeave) begin
                    next_s.state = net_join_pkg::ST_IDLE;
                end else begin
                    next_s.holdCnt = 18'(s.holdCnt - 18'h1);
                end
            end
        endcase
        if (s.state != net_join_pkg::ST_HOLD) begin
            next_s.holdCnt = 18'(RETRY_HOLD_CYCLES - 1);
        end

        // New settings restart the whole join sequence
        if (applyChanges) begin
            next_s.state = net_join_pkg::ST_IDLE;
            next_s.joined = 1'b0;
            next_s.permit = 1'b0;
        end
    end

    // ==========================================================
    // Register
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            s <= '0;
            s.state <= net_join_pkg::ST_IDLE;
            s.edOpts <= `ED_OPTS_RESET;
            s.coOpts <= `CO_OPTS_RESET;
            s.code <= `RC_BUSY;
        end else begin
            s <= next_s;
        end
    end

    assign paramRdata = s.paramRdata;
    assign paramError = s.paramError;
    assign activeScanReq = s.activeScanReq;
    assign energyScanReq = s.energyScanReq;
    assign scanExponent = s.scanExp;
    assign assocReq = s.assocReq;
    assign targetNet = s.workNet;
    assign targetChan = s.workChan;
    assign startReq = s.startReq;
    assign pollReq = s.pollReq;
    assign disassocReq = s.disassocReq;
    assign joined = s.joined;
    assign permitJoin = s.permit;

    // ==========================================================
    // Checks
    sequence s_drop;
        disassocReq && !joined;
    endsequence
    sequence s_rejoin;
        ##[1:2] activeScanReq;
    endsequence

    a_reset_options: assert property (@(posedge mclk)
        !nrst |=> s.coOpts == 3'h6 && s.edOpts == 4'h0)
        else $error("options not at reset values");
    a_option_range: assert property (@(posedge mclk) disable iff (!nrst)
        paramWrite && paramAddr == `PAR_ED_OPTS && paramWdata > 8'h0f
        |=> paramError && $stable(s.edOpts))
        else $error("out of range option write accepted");
    a_result_ro: assert property (@(posedge mclk) disable iff (!nrst)
        paramWrite && paramAddr == `PAR_RESULT && !applyChanges &&
        s.state == net_join_pkg::ST_JOINED && !forceLeave && !syncLoss &&
        !linkLost |=> $stable(s.code))
        else $error("result code changed by a write");
    a_busy_code: assert property (@(posedge mclk) disable iff (!nrst)
        s.state == net_join_pkg::ST_ASSOC |-> s.code == 8'hff)
        else $error("result not busy during join");
    a_joined_ok: assert property (@(posedge mclk) disable iff (!nrst)
        s.state == net_join_pkg::ST_JOINED |-> s.code == 8'h00 && joined)
        else $error("joined without success code");
    a_permit_follow: assert property (@(posedge mclk) disable iff (!nrst)
        permitJoin |-> $past(roleCoord) && $past(s.coOpts[2]))
        else $error("joins permitted while option clear");
    a_poll_defer: assert property (@(posedge mclk) disable iff (!nrst)
        pollReq |-> !$past(commandMode))
        else $error("poll sent in command mode");
    a_no_attempt: assert property (@(posedge mclk) disable iff (!nrst)
        s.state == net_join_pkg::ST_IDLE && !roleCoord && !applyChanges &&
        !s.edOpts[2] && !beaconEnabled |=> !activeScanReq)
        else $error("join attempted with auto-join off");
    a_leave_rejoin: assert property (@(posedge mclk) disable iff (!nrst)
        s.state == net_join_pkg::ST_JOINED && forceLeave && !applyChanges &&
        !roleCoord && (s.edOpts[2] || beaconEnabled) ##1 !applyChanges
        |-> s_drop ##0 s_rejoin)
        else $error("force-leave did not drop and rejoin");
    a_pin_poll: assert property (@(posedge mclk) disable iff (!nrst)
        pinWake && !roleCoord && s.edOpts[3] ##1
        (s.state == net_join_pkg::ST_JOINED && !commandMode) |=> pollReq)
        else $error("pin wake did not poll");

endmodule
`default_nettype wire

// ==== dv/network_association_control_tb_top.sv ====
// Self-checking bench for the association control block
`timescale 1ns/1ps
`default_nettype none
module network_association_control_tb_top;
    typedef struct {logic [1:0] a; logic [7:0] d, q; logic e;} row_t;
    logic mclk = 0, nrst = 0, paramWrite = 0, commandMode = 0;
    logic applyChanges = 0, forceLeave = 0, forcePoll = 0, roleCoord = 0;
    logic linkLost = 0, paramError, activeScanReq, energyScanReq;
    logic assocReq, startReq, pollReq, disassocReq, joined, permitJoin;
    logic scanDone, beaconValid, assocDone, startDone;
    logic [1:0] paramAddr = 2'h0;
    logic [7:0] paramWdata = 8'h00, paramRdata;
    logic [15:0] targetNet;
    logic [4:0] targetChan;
    logic pinWake = 0, syncLoss = 0, scanTimeout = 0, beaconEnabled = 0;
    logic beaconMode = 0, beaconPermit = 1;
    logic [15:0] beaconNet = 16'h4321;
    logic [7:0] assocStatus = 8'h00;
    logic [1:0] startStatus = 2'h0;
    logic [3:0] scanExponent;
    int err_count = 0, samples_checked = 0, polls = 0;
    // Option writes: rows first, then
    row_t rows [6] = '{'{2'h0, 8'h09, 8'h09, 1'h0},
        '{2'h0, 8'h10, 8'h09, 1'h1}, '{2'h1, 8'h07, 8'h07, 1'h0},
        '{2'h1, 8'h08, 8'h07, 1'h1}, '{2'h2, 8'h00, 8'hff, 1'h0},
        '{2'h1, 8'h06, 8'h06, 1'h0}};
    network_association_control #(.RETRY_HOLD_CYCLES(8))
    i_network_association_control (
        .mclk, .nrst, .paramWrite, .paramAddr, .paramWdata, .paramRdata,
        .paramError, .commandMode, .applyChanges, .forceLeave, .forcePoll,
        .roleCoord, .beaconEnabled, .networkId(16'h1234),
        .channelSetting(5'h0b), .scanDurExp(4'h3), .pinWake,
        .activeScanReq, .energyScanReq, .scanExponent, .scanDone,
        .scanTimeout, .beaconValid, .beaconNet,
        .beaconChan(5'h0c), .beaconPermit, .beaconMode,
        .quietChannel(5'h0f), .assocReq, .targetNet, .targetChan,
        .assocDone, .assocStatus, .startReq, .startDone,
        .startStatus, .syncLoss, .linkLost, .pollReq,
        .disassocReq, .joined, .permitJoin);
    radio_peer_model i_radio_peer_model (.mclk,
        .scanGo(activeScanReq | energyScanReq), .joinGo(assocReq),
        .startGo(startReq), .beaconValid, .scanDone, .assocDone, .startDone);
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) if (pollReq === 1'b1) polls++;
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        tick(1);
        s = 0;
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        paramAddr = a;
        paramWdata = d;
        pulse(paramWrite);
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        paramAddr = a;
        tick(2);
        chk("paramRdata", {8'h00, e}, {8'h00, paramRdata});
    endtask
    // Sel 0 joined, 1 scanDone, 2 permitJoin; a hang ends the run
    task automatic waitFor(input int s);
        int n;
        n = 0;
        while (n < 300 && (s == 0 ? joined : s == 1 ? scanDone
                : permitJoin) !== 1'b1) begin
            tick(1);
            n++;
        end
        if (n == 300) begin
            err_count++;
            $display("unexpected wait %0d expected 1 seen 0", s);
            report_and_stop();
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        tick(20);
        nrst = 1;
        rd(2'h0, 8'h00);
        rd(2'h1, 8'h06);
        rd(2'h2, 8'hff);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            chk("paramError", 16'(rows[i].e), 16'(paramError));
            rd(rows[i].a, rows[i].q);
        end
        $display("test options done");
        wr(2'h0, 8'h07);
        tick(3);
        rd(2'h2, 8'hff);
        waitFor(0);
        rd(2'h2, 8'h00);
        chk("targetNet", 16'h4321, targetNet);
        chk("scanExponent", 16'h3, 16'(scanExponent));
        wr(2'h2, 8'h05);
        rd(2'h2, 8'h00);
        commandMode = 1;
        pulse(forcePoll);
        tick(6);
        chk("polls", 16'h0, 16'(polls));
        commandMode = 0;
        tick(6);
        chk("polls", 16'h1, 16'(polls));
        pulse(pinWake);
        tick(3);
        chk("polls", 16'h1, 16'(polls));
        wr(2'h0, 8'h0f);
        pulse(pinWake);
        tick(3);
        chk("polls", 16'h2, 16'(polls));
        pulse(forceLeave);
        chk("disassocReq", 16'h1, 16'(disassocReq));
        chk("joined", 16'h0, 16'(joined));
        waitFor(0);
        pulse(linkLost);
        rd(2'h2, 8'h13);
        waitFor(0);
        pulse(syncLoss);
        rd(2'h2, 8'h12);
        // Join answer lands six cycles after the scan ends
        assocStatus = 8'h0e;
        waitFor(1);
        tick(6);
        rd(2'h2, 8'h0e);
        assocStatus = 8'h00;
        wr(2'h0, 8'h06);
        waitFor(1);
        rd(2'h2, 8'h05);
        wr(2'h0, 8'h05);
        waitFor(1);
        rd(2'h2, 8'h06);
        beaconPermit = 0;
        waitFor(1);
        rd(2'h2, 8'h03);
        beaconPermit = 1;
        scanTimeout = 1;
        waitFor(1);
        rd(2'h2, 8'h01);
        scanTimeout = 0;
        wr(2'h0, 8'h00);
        beaconEnabled = 1;
        waitFor(1);
        rd(2'h2, 8'h04);
        beaconEnabled = 0;
        tick(20);
        rd(2'h2, 8'h04);
        $display("test end device done");
        roleCoord = 1;
        pulse(applyChanges);
        waitFor(2);
        chk("targetChan", 16'h0f, 16'(targetChan));
        rd(2'h2, 8'h00);
        wr(2'h1, 8'h02);
        pulse(applyChanges);
        tick(30);
        chk("permitJoin", 16'h0, 16'(permitJoin));
        rd(2'h2, 8'h00);
        startStatus = 2'h2;
        pulse(applyChanges);
        tick(13);
        rd(2'h2, 8'h09);
        startStatus = 2'h0;
        beaconNet = 16'h1234;
        wr(2'h1, 8'h07);
        pulse(applyChanges);
        waitFor(2);
        chk("targetNet", 16'h1235, targetNet);
        $display("test coordinator done");
        nrst = 0;
        tick(2);
        nrst = 1;
        rd(2'h1, 8'h06);
        chk("permitJoin", 16'h0, 16'(permitJoin));
        $display("test reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire

// ==== dv/radio_peer_model.sv ====
// Behavioural radio side: scan, join and start answers
`timescale 1ns/1ps
`default_nettype none
module radio_peer_model (
    input wire logic mclk,    // Clock
    input wire logic scanGo,  // Scan request
    input wire logic joinGo,  // Join request
    input wire logic startGo, // Start request
    output logic beaconValid, // Beacon heard
    output logic scanDone,    // Scan over
    output logic assocDone,   // Join answer
    output logic startDone    // Start answer
);
    logic [2:0] cnt = 3'h0;
    logic [1:0] kind = 2'h0;
    // Answers come late, so the design has to wait for them
    always @(posedge mclk) begin
        if (scanGo | joinGo | startGo) begin
            cnt <= 3'h5;
            kind <= scanGo ? 2'h1 : (joinGo ? 2'h2 : 2'h3);
        end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
        end
    end
    assign beaconValid = kind == 2'h1 && cnt == 3'h3;
    assign scanDone = kind == 2'h1 && cnt == 3'h1;
    assign assocDone = kind == 2'h2 && cnt == 3'h1;
    assign startDone = kind == 2'h3 && cnt == 3'h1;
endmodule
`default_nettype wire
